// [verilog/dcr_bank.sv]
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - crc status sets after 1, 2, 4 or 8 consecutive bad frames.
// - clock pin carries oscillator, optionally divided by 128.
// - modem interrupt enable sends a break on the uart line, only when the baud bit selects 9600.
// - clear pin enable turns sdi into a clear input.
// - baud bit picks 1200 without break or 9600 with break.
// - crc checked only while crc enable is set.
// - interrupt pin enabled, active low or high by polarity.
// - interrupt is a held level or a pulse on the event.
// - sdo tri-stated when disabled, else driven while selected.
// - sdo launched on rising edge, or falling edge when early.
// - power-down disables the output buffer.
// - slew clock code 0 to 7 halves from 307.2 kHz.
// - slew step is two to the power of the step code.
// - slew ramps toward new codes, linear or soft-ended.
// - clear force holds the output in its clear state.
// - in clear state the clear span bit picks the span.
// - in normal state the span bit picks the span.
// - gain trim scales output from 0.5 to nearly 1.5.
// - signed offset trim is added to the output code.
// - clear state applies the fallback code.
// - writing the key to the reset field resets the bank.
module dcr_bank
    import dcr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic [15:0] dac_code,
    input wire logic crc_status_clear,
    output logic [15:0] dac_out_code,
    output logic dac_in_clear,
    output logic output_span_narrow,
    output logic output_buffer_powerdown,
    output logic slew_tick,
    output logic clock_out_pin,
    output logic uart_tx_pin,
    output logic uart_baud_9600,
    output logic uart_disable_cfg,
    output logic interrupt_pin,
    output logic interrupt_oe_n,
    output logic crc_error_status,
    output logic soft_reset_pulse
);
    // ****************************************************
    // declarations
    // ****************************************************
    dcr_bank_s st, next_st;
    dcr_frame_s frame;
    logic frame_valid;
    logic sdi_level;
    logic [15:0] rd_data;
    logic irq_active;
    logic clr_state;
    logic wr_ok;

    // ****************************************************
    // serial port
    // ****************************************************
    dcr_spi_port u_port (
        .clock(clock),
        .nrst(nrst),
        .sclk(spi_sclk),
        .cs_n(spi_cs_n),
        .sdi(spi_sdi),
        .crc_enable(st.ifc[IFC_CRCEN]),
        .early_launch(st.ifc[IFC_SERIAL_OUT_EARLY]),
        .out_disable(st.ifc[IFC_SERIAL_OUT_DISABLE]),
        .rd_data(rd_data),
        .sdo(spi_sdo),
        .sdo_oe_n(spi_sdo_oe_n),
        .sdi_level(sdi_level),
        .frame_valid(frame_valid),
        .frame(frame)
    );

    // readback; reserved bits are zero in storage
    always_comb begin
        unique case (frame.addr)
            ADDR_IFC: rd_data = st.ifc;
            ADDR_OUT: rd_data = st.outc;
            ADDR_GAIN: rd_data = st.gain;
            ADDR_SHIFT: rd_data = st.shift;
            ADDR_FALL: rd_data = st.fall;
            default: rd_data = 16'h0000;
        endcase
    end

    // a write counts only when its check passed
    assign wr_ok = frame_valid && !frame.rd
        && !(st.ifc[IFC_CRCEN] && frame.crc_bad);

    // clear from register or from the reused sdi pin
    assign clr_state = st.outc[OUT_CLR]
        | (st.ifc[IFC_CLRPIN] & sdi_level);

    // interrupt level or stretched edge
    assign irq_active = st.ifc[IFC_LVL] ? st.stat
        : (st.pulse != 5'h00);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic [16:0] acc;
        logic half;
        logic rise;
        logic [10:0] msk;
        logic [15:0] step;
        logic [15:0] rem;
        logic [4:0] lim;
        logic [32:0] prod;
        logic [17:0] sum;
        acc = 17'h00000;
        half = 1'b0;
        rise = 1'b0;
        msk = 11'h000;
        step = 16'h0000;
        rem = 16'h0000;
        lim = 5'h00;
        prod = 33'h000000000;
        sum = 18'h00000;
        next_st = st;
        next_st.srst = 1'b0;

        // oscillator half-period ticks from a phase accumulator
        acc = {1'b0, st.nco} + {1'b0, NCO_INC};
        next_st.nco = acc[15:0];
        half = acc[16];
        if (half) begin
            next_st.hc = st.hc + 11'h001;
        end

        // clock pin, full rate or divided by 128
        next_st.ck = st.ifc[IFC_CKEN]
            & (st.ifc[IFC_CKDIV] ? st.hc[7] : st.hc[0]);

        // register writes
        if (wr_ok) begin
            unique case (frame.addr)
                ADDR_IFC: begin
                    next_st.ifc = frame.data & IFC_WMASK;
                end
                ADDR_OUT: begin
                    next_st.outc = frame.data & OUT_WMASK;
                end
                ADDR_GAIN: begin
                    next_st.gain = frame.data;
                end
                ADDR_SHIFT: begin
                    next_st.shift = frame.data;
                end
                ADDR_FALL: begin
                    next_st.fall = frame.data;
                end
                ADDR_SRST: begin
                    // only the key starts a reset
                    next_st.srst = (frame.data[7:0] == SRST_KEY);
                end
                default: begin
                end
            endcase
        end

        // consecutive check failures against the run limit
        lim = 5'h01 << st.ifc[IFC_RUN_LO +: 2];
        if (frame_valid && st.ifc[IFC_CRCEN]) begin
            if (frame.crc_bad) begin
                if (st.run != 4'h8) begin
                    next_st.run = st.run + 4'h1;
                end
                if ({1'b0, st.run} + 5'h01 >= lim) begin
                    next_st.stat = 1'b1;
                end
            end else begin
                next_st.run = 4'h0;
            end
        end
        // clear loses to a set in the same cycle
        if (crc_status_clear && !next_st.stat) begin
            next_st.stat = 1'b0;
        end else if (crc_status_clear && st.stat
                     && next_st.stat == st.stat
                     && !(frame_valid && frame.crc_bad
                          && {1'b0, st.run} + 5'h01 >= lim)) begin
            next_st.stat = 1'b0;
        end

        // edge mode stretches the event into a pulse
        rise = st.stat & ~st.prev;
        next_st.prev = st.stat;
        if (rise && !st.ifc[IFC_LVL]) begin
            next_st.pulse = IRQ_PULSE_CYC;
        end else if (st.pulse != 5'h00) begin
            next_st.pulse = st.pulse - 5'h01;
        end

        // break on the uart line, only in 9600 baud mode
        if (rise && st.ifc[IFC_MODEM]
            && st.ifc[IFC_BAUD]) begin
            next_st.brk = BREAK_BITS;
        end else if (half && st.hc[7:0] == 8'hFF
                     && st.brk != 4'h0) begin
            next_st.brk = st.brk - 4'h1;
        end

        // slew step, halved near the target in soft shape
        step = 16'h0001 << st.outc[OUT_STEP_LO +: 3];
        rem = (dac_code > st.slew) ? dac_code - st.slew
                                   : st.slew - dac_code;
        if (st.outc[OUT_SHAPE] && step != 16'h0001
            && rem < {step[13:0], 2'b00}) begin
            step = {1'b0, step[15:1]};
        end
        msk = (11'h008 << st.outc[OUT_SRCLK_LO +: 3]) - 11'h001;
        if (!st.outc[OUT_SREN]) begin
            next_st.slew = dac_code;
        end else if (half && (st.hc & msk) == msk) begin
            if (rem <= step) begin
                next_st.slew = dac_code;
            end else if (dac_code > st.slew) begin
                next_st.slew = st.slew + step;
            end else begin
                next_st.slew = st.slew - step;
            end
        end

        // gain 0.5 to 1.5 then signed offset, clamped
        prod = 33'(st.slew) * 33'({1'b0, st.gain} + 17'h08000);
        sum = {1'b0, prod[32:16]}
            + {{2{st.shift[15]}}, st.shift};
        if (clr_state) begin
            next_st.code = st.fall;
        end else if (sum[17]) begin
            next_st.code = 16'h0000;
        end else if (sum[16]) begin
            next_st.code = 16'hFFFF;
        end else begin
            next_st.code = sum[15:0];
        end

        // keyed reset restores this bank only
        if (st.srst) begin
            next_st.ifc = IFC_RST;
            next_st.outc = OUT_RST;
            next_st.gain = GAIN_RST;
            next_st.shift = SHIFT_RST;
            next_st.fall = FALL_RST;
            next_st.run = 4'h0;
            next_st.stat = 1'b0;
            next_st.pulse = 5'h00;
            next_st.brk = 4'h0;
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.ifc <= IFC_RST;
            st.outc <= OUT_RST;
            st.gain <= GAIN_RST;
            st.shift <= SHIFT_RST;
            st.fall <= FALL_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign dac_out_code = st.code;
    assign dac_in_clear = clr_state;
    // span bit depends on the state
    assign output_span_narrow = clr_state
        ? st.outc[OUT_CLRSPAN]
        : st.outc[OUT_SPAN];
    assign output_buffer_powerdown = st.outc[OUT_PD];
    assign slew_tick = st.slew != next_st.slew;
    assign clock_out_pin = st.ck;
    assign uart_tx_pin = (st.brk == 4'h0);
    assign uart_baud_9600 = st.ifc[IFC_BAUD];
    assign uart_disable_cfg = st.ifc[IFC_UARTDIS];
    // polarity and pin enable
    assign interrupt_pin = st.ifc[IFC_POL] ? irq_active
        : ~irq_active;
    assign interrupt_oe_n = ~st.ifc[IFC_IRQEN];
    assign crc_error_status = st.stat;
    assign soft_reset_pulse = st.srst;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_key;
        wr_ok && frame.addr == ADDR_SRST
            && frame.data[7:0] == SRST_KEY;
    endsequence

    sequence s_bad_key;
        wr_ok && frame.addr == ADDR_SRST
            && frame.data[7:0] != SRST_KEY;
    endsequence

    sequence s_rise;
        !st.stat ##1 st.stat;
    endsequence

    property p_run_one;
        (frame_valid && frame.crc_bad && st.ifc[IFC_CRCEN]
            && st.ifc[IFC_RUN_LO +: 2] == 2'h0 && !st.srst)
            |=> st.stat;
    endproperty
    a_run_one: assert property (p_run_one)
        else $error("status not set after one bad frame");

    property p_run_eight;
        (frame_valid && frame.crc_bad && !st.stat
            && st.ifc[IFC_RUN_LO +: 2] == 2'h3 && st.run < 4'h6)
            |=> !st.stat;
    endproperty
    a_run_eight: assert property (p_run_eight)
        else $error("status set before eight bad frames");

    property p_ck_off;
        !st.ifc[IFC_CKEN] |=> !clock_out_pin;
    endproperty
    a_ck_off: assert property (p_ck_off)
        else $error("clock pin toggles while disabled");

    property p_break_gate;
        $fell(uart_tx_pin)
            |-> $past(st.ifc[IFC_MODEM] && st.ifc[IFC_BAUD]);
    endproperty
    a_break_gate: assert property (p_break_gate)
        else $error("break without enable or 9600 baud");

    property p_irq_low;
        (st.ifc[IFC_IRQEN] && !st.ifc[IFC_POL] && irq_active)
            |-> (!interrupt_pin && !interrupt_oe_n);
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("active low interrupt not driven low");

    property p_irq_edge;
        (s_rise ##0 !st.ifc[IFC_LVL]) |=> irq_active [*8];
    endproperty
    a_irq_edge: assert property (p_irq_edge)
        else $error("edge interrupt pulse too short");

    property p_clear_code;
        (st.outc[OUT_CLR] && $stable(st.fall))
            |=> dac_out_code == $past(st.fall);
    endproperty
    a_clear_code: assert property (p_clear_code)
        else $error("clear state lost fallback code");

    property p_srst;
        s_key |=> st.srst ##1
            (st.ifc == IFC_RST && st.outc == OUT_RST);
    endproperty
    a_srst: assert property (p_srst)
        else $error("key write did not reset the bank");

    property p_bad_key;
        s_bad_key |=> !st.srst;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key started a reset");
endmodule
`default_nettype wire

// [verilog/dcr_pkg.sv]
`default_nettype none
package dcr_pkg;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_HZ = 20000000;
    localparam int CLK_NS = 50;
    localparam int OSC_HZ = 1228800;
    // accumulator step for a 2 x OSC_HZ toggle rate
    localparam logic [15:0] NCO_INC =
        16'((64'(OSC_HZ) * 64'd131072) / 64'(CLK_HZ));
    localparam int IRQ_PULSE_NS = 1000;
    localparam logic [4:0] IRQ_PULSE_CYC =
        5'((IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] BREAK_BITS = 4'hC;
    // ****************************************************
    // serial frame
    // ****************************************************
    localparam logic [5:0] FRAME_BITS = 6'h18;
    localparam logic [5:0] CRC_BITS = 6'h08;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [6:0] ADDR_IFC = 7'h02;
    localparam logic [6:0] ADDR_OUT = 7'h03;
    localparam logic [6:0] ADDR_GAIN = 7'h04;
    localparam logic [6:0] ADDR_SHIFT = 7'h05;
    localparam logic [6:0] ADDR_FALL = 7'h06;
    localparam logic [6:0] ADDR_SRST = 7'h07;
    localparam logic [15:0] IFC_RST = 16'h0036;
    localparam logic [15:0] OUT_RST = 16'h0B00;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    localparam logic [15:0] FALL_RST = 16'h0000;
    localparam logic [15:0] IFC_WMASK = 16'h7BFF;
    localparam logic [15:0] OUT_WMASK = 16'h1FF7;
    localparam logic [7:0] SRST_KEY = 8'hAD;
    // interface_config fields
    localparam int IFC_RUN_LO = 13;
    localparam int IFC_CKDIV = 12;
    localparam int IFC_CKEN = 11;
    localparam int IFC_MODEM = 9;
    localparam int IFC_IRQEN = 8;
    localparam int IFC_CLRPIN = 7;
    localparam int IFC_UARTDIS = 6;
    localparam int IFC_BAUD = 5;
    localparam int IFC_CRCEN = 4;
    localparam int IFC_POL = 3;
    localparam int IFC_LVL = 2;
    localparam int IFC_SERIAL_OUT_DISABLE = 1;
    localparam int IFC_SERIAL_OUT_EARLY = 0;
    // output_config fields
    localparam int OUT_PD = 12;
    localparam int OUT_SRCLK_LO = 9;
    localparam int OUT_STEP_LO = 6;
    localparam int OUT_SREN = 5;
    localparam int OUT_SHAPE = 4;
    localparam int OUT_CLR = 2;
    localparam int OUT_CLRSPAN = 1;
    localparam int OUT_SPAN = 0;
    // ****************************************************
    // carriers and state
    // ****************************************************
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [15:0] data;
        logic crc_bad;
    } dcr_frame_s;
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic sclk_q;
        logic cs_q;
        logic [5:0] cnt;
        logic [31:0] sh;
        logic [7:0] crc;
        logic [23:0] tx;
        logic sdo;
        logic valid;
        dcr_frame_s frame;
    } dcr_spi_s;
    typedef struct packed {
        logic [15:0] ifc;
        logic [15:0] outc;
        logic [15:0] gain;
        logic [15:0] shift;
        logic [15:0] fall;
        logic [3:0] run;
        logic stat;
        logic prev;
        logic [4:0] pulse;
        logic [3:0] brk;
        logic [15:0] nco;
        logic [10:0] hc;
        logic ck;
        logic [15:0] slew;
        logic [15:0] code;
        logic srst;
    } dcr_bank_s;
endpackage
`default_nettype wire

// [verilog/dcr_spi_port.sv]
`timescale 1ns/100ps
`default_nettype none
module dcr_spi_port
    import dcr_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic crc_enable,
    input wire logic early_launch,
    input wire logic out_disable,
    input wire logic [15:0] rd_data,
    output logic sdo,
    output logic sdo_oe_n,
    output logic sdi_level,
    output logic frame_valid,
    output dcr_frame_s frame
);
    dcr_spi_s st, next_st;
    logic l_rise, l_fall;

    // edges of the synchronised serial clock
    assign l_rise = st.s2[0] & ~st.sclk_q;
    assign l_fall = ~st.s2[0] & st.sclk_q;

    // ****************************************************
    // frame shifter
    // ****************************************************
    always_comb begin
        logic launch;
        logic fb;
        logic [23:0] w;
        launch = 1'b0;
        fb = 1'b0;
        w = 24'h000000;
        next_st = st;
        next_st.valid = 1'b0;
        next_st.s1 = {sdi, cs_n, sclk};
        next_st.s2 = st.s1;
        next_st.sclk_q = st.s2[0];
        next_st.cs_q = st.s2[1];
        launch = early_launch ? l_fall : l_rise;
        fb = st.crc[7] ^ st.s2[2];
        w = crc_enable ? st.sh[31:8] : st.sh[23:0];
        if (!st.s2[1] && st.cs_q) begin
            next_st.cnt = 6'h00;
            next_st.crc = CRC_INIT;
            next_st.sdo = st.tx[23];
            next_st.tx = {st.tx[22:0], 1'b0};
        end else if (!st.s2[1]) begin
            if (l_fall) begin
                next_st.sh = {st.sh[30:0], st.s2[2]};
                if (st.cnt != 6'h3F) begin
                    next_st.cnt = st.cnt + 6'h01;
                end
                if (st.cnt < FRAME_BITS) begin
                    next_st.crc = {st.crc[6:0], 1'b0}
                        ^ (fb ? CRC_POLY : 8'h00);
                end
            end
            if (launch) begin
                next_st.sdo = st.tx[23];
                next_st.tx = {st.tx[22:0], 1'b0};
            end
        end else if (!st.cs_q) begin
            next_st.tx = 24'h000000;
            if (st.cnt == (crc_enable ? FRAME_BITS + CRC_BITS
                                      : FRAME_BITS)) begin
                next_st.valid = 1'b1;
                next_st.frame.rd = w[23];
                next_st.frame.addr = w[22:16];
                next_st.frame.data = w[15:0];
                // no check while disabled
                next_st.frame.crc_bad = crc_enable
                    && (st.sh[7:0] != st.crc);
            end
        end
        // readback goes out in the following frame
        if (st.valid && st.frame.rd) begin
            next_st.tx = {1'b0, st.frame.addr, rd_data};
        end
    end

    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.s1 <= 3'h2;
            st.s2 <= 3'h2;
            st.cs_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // pin side
    assign sdo = st.sdo;
    assign sdo_oe_n = out_disable | st.s2[1];
    assign sdi_level = st.s2[2];
    assign frame_valid = st.valid;
    assign frame = st.frame;

    // ****************************************************
    // checks
    // ****************************************************
    property p_sdo_drive;
        @(posedge clock) disable iff (!nrst)
        (!out_disable && !st.s2[1]) |-> !sdo_oe_n;
    endproperty
    a_sdo_drive: assert property (p_sdo_drive)
        else $error("sdo not driven in frame");

    property p_crc_skip;
        @(posedge clock) disable iff (!nrst)
        (!crc_enable ##1 st.valid) |-> !st.frame.crc_bad;
    endproperty
    a_crc_skip: assert property (p_crc_skip)
        else $error("crc flagged while disabled");

    property p_launch;
        @(posedge clock) disable iff (!nrst)
        ($changed(st.sdo) && !$past(early_launch)
            && !$past(st.cs_q)) |-> $past(l_rise);
    endproperty
    a_launch: assert property (p_launch)
        else $error("sdo moved off rising edge");
endmodule
`default_nettype wire

// [bench/dcr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module dcr_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_w
);
    // frame length in bits, 24 when the check byte is off
    int nbits = 32;
    // check byte over the 24 frame bits, msb first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame of nbits bits, sdo sampled before each rising sclk
    task automatic xfer(input logic [23:0] w, input logic bad,
        output logic [23:0] r);
        logic [31:0] f;
        f = {w, crc8(w) ^ {8{bad}}};
        r = 24'h0;
        cs_n = 1'b0;
        #200;
        for (int i = 31; i >= 32 - nbits; i--) begin
            #200;
            if (i > 7) r[i-8] = sdo_w;
            // data moves with rising sclk, stable at the falling capture
            sclk = 1'b1;
            sdi = f[i];
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        sdi = ~sdi;
        #400;
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
    import dcr_pkg::*;
;
    logic clock, nrst, sclk, cs_n, sdi, sdo, sdo_oe_n, sdo_hold, crc_clr;
    logic [15:0] dac_code, out_code, d;
    logic in_clear, narrow, pd, baud, irq, irq_oe_n, crc_stat, ck_out;
    logic [15:0] m [0:127];
    logic [31:0] seed;
    logic [23:0] r;
    logic [6:0] a;
    int num_errors, check_count;
    wire logic sdo_w = sdo_oe_n ? ~sdo_hold : sdo;
    dcr_host host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_w(sdo_w));
    dcr_bank dut_u (.clock(clock), .nrst(nrst), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo),
        .spi_sdo_oe_n(sdo_oe_n), .dac_code(dac_code),
        .crc_status_clear(crc_clr), .dac_out_code(out_code),
        .dac_in_clear(in_clear), .output_span_narrow(narrow),
        .output_buffer_powerdown(pd), .slew_tick(), .clock_out_pin(ck_out),
        .uart_tx_pin(), .uart_baud_9600(baud), .uart_disable_cfg(),
        .interrupt_pin(irq), .interrupt_oe_n(irq_oe_n),
        .crc_error_status(crc_stat), .soft_reset_pulse());
    // clock and released-line memory
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) if (!sdo_oe_n) sdo_hold <= sdo;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic mreset();
        foreach (m[i]) m[i] = 16'h0000;
        m[2] = 16'h0036;
        m[3] = 16'h0B00;
        m[4] = 16'h8000;
    endtask
    task automatic wr(input logic [6:0] ad, input logic [15:0] dd,
        input logic bad);
        host_u.xfer({1'b0, ad, dd}, bad, r);
        if (!bad && ad == 7 && dd[7:0] == 8'hAD) mreset();
        else if (!bad && ad == 2) m[2] = dd & 16'h7BFF;
        else if (!bad && ad == 3) m[3] = dd & 16'h1FF7;
        else if (!bad && ad > 3 && ad < 7) m[ad] = dd;
    endtask
    task automatic rd(input logic [6:0] ad);
        host_u.xfer({1'b1, ad, 16'h0000}, 1'b0, r);
        host_u.xfer({1'b1, 7'h00, 16'h0000}, 1'b0, r);
        chk("read", m[ad], r[15:0]);
    endtask
    // gain then signed offset, clamped to the code range
    function automatic logic [15:0] exp_out(input logic [15:0] c);
        longint v;
        v = (longint'(c) * (longint'(m[4]) + 32768)) >>> 16;
        v = v + longint'($signed(m[5]));
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return v[15:0];
    endfunction
    task automatic complete_run();
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        num_errors++;
        complete_run();
    end
    initial begin
        nrst = 1'b0;
        dac_code = 16'h0000;
        crc_clr = 1'b0;
        sdo_hold = 1'b0;
        seed = 32'h04B7;
        mreset();
        repeat (8) @(posedge clock);
        #5 nrst = 1'b1;
        repeat (4) @(posedge clock);
        #5;
        chk("sdo_oe_n", 1, sdo_oe_n);
        wr(2, 16'h0034, 0);
        for (int k = 2; k < 8; k++) rd(7'(k));
        // random register traffic, one unmapped place among them
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            a = (k % 7 == 6) ? 7'h11 : 7'(k % 7 + 2);
            d = seed[15:0];
            if (a == 2) d = (d & 16'hFF6D) | 16'h0010;
            if (a == 7 && d[7:0] == 8'hAD) d[0] = 1'b0;
            wr(a, d, 0);
            rd(a);
            chk("baud", 16'(m[2][5]), baud);
            if (!m[2][11]) chk("clk_out", 0, ck_out);
        end
        // bad check bytes, run limit of two frames, high level irq
        wr(2, 16'h211C, 0);
        wr(4, 16'h1234, 1);
        chk("status", 0, crc_stat);
        wr(4, 16'h1234, 1);
        chk("status", 1, crc_stat);
        chk("irq", 1, irq);
        chk("irq_oe_n", 0, irq_oe_n);
        rd(4);
        crc_clr = 1'b1;
        #50 crc_clr = 1'b0;
        #100;
        chk("irq", 0, irq);
        // check byte off: only 24-bit frames are taken
        wr(2, 16'h210C, 0);
        host_u.nbits = 24;
        wr(4, 16'h4321, 0);
        rd(4);
        wr(2, 16'h211C, 0);
        host_u.nbits = 32;
        // normal output path
        wr(3, 16'h0001, 0);
        chk("narrow", 1, narrow);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(4, seed[15:0], 0);
            wr(5, {{8{seed[23]}}, seed[23:16]}, 0);
            dac_code = 16'(lfsr(seed) >> 16);
            #200;
            chk("out", exp_out(dac_code), out_code);
        end
        // sdi reused as clear input
        wr(2, 16'h219C, 0);
        host_u.sdi = 1'b1;
        #200 chk("in_clear", 1, in_clear);
        host_u.sdi = 1'b0;
        #200 chk("in_clear", 0, in_clear);
        // clear state with fallback code and power-down
        wr(6, seed[31:16], 0);
        wr(3, 16'h1005, 0);
        chk("in_clear", 1, in_clear);
        chk("out", m[6], out_code);
        chk("narrow", 0, narrow);
        chk("pd", 1, pd);
        wr(7, 16'h00AC, 0);
        chk("in_clear", 1, in_clear);
        wr(7, 16'h00AD, 0);
        chk("in_clear", 0, in_clear);
        chk("pd", 0, pd);
        chk("sdo_oe_n", 1, sdo_oe_n);
        complete_run();
    end
endmodule
`default_nettype wire
